/* uirl_top.sv */
// Purpose: Interrupt masking, status and ready pins of a dual UART.
// Assumes: FIFO levels, triggers, errors and modem deltas come from
//          the same clock domain; only clear-to-send arrives from a pin.
// Notes:   Registers of all channels share one plain register port.
//
// Behaviour
// - Mask bit 7 set: interrupt on each clear-to-send low-to-high edge.
// - Mask bit 6 set: interrupt on each request-to-send low-to-high edge.
// - Mask bit 5 gates the stop-character received interrupt.
// - Mask bit 4 one permits sleep; zero keeps sleep disabled.
// - Mask bit 3 set: interrupt while any of four modem deltas active.
// - Mask bit 2 set: interrupt while any receive error or break active.
// - Mask bit 1 set: transmit interrupt when holding path or FIFO empty.
// - Mask bit 0, no FIFO: receive interrupt while holding register full.
// - FIFO mode: receive interrupt while fill at or above trigger.
// - Receive status bit follows trigger reached, clears with interrupt.
// - Receive data bit set on character arrival, cleared when empty.
// - FIFO drained interrupt cleared by status read or new character.
// - FIFO on with masks 0-3 and 5-7 clear: polling only, no interrupts.
// - Line bit 5 is transmit empty; bit 6 adds shifter empty.
// - Line bits 4:1 give error type; bit 7 flags FIFO data error.
// - Ready mode 0: transmit ready low when empty, receive on data.
// - Ready mode 1: transmit ready low while fill below trigger.
// - Ready mode 1: receive ready low from trigger; FIFO keeps filling.
// - After reset every mask bit reads zero.
// - Ready mode 1: time-out also asserts receive ready; high when empty.
// - Ready mode 0: transmit ready goes high after first character.
//
// Implementation choices: the register addresses and the plain strobed port.

module uirl_chan
  import uirl_pkg::*;
#(
  parameter int LEVEL_W = UIRL_LEVEL_W
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  // Local register port
  input  wire logic [uirl_pkg::UIRL_SEL_W-1:0] reg_sel,
  input  wire logic [7:0]                    wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [7:0]                    rdata,
  // FIFO and serial engine state
  input  wire logic                          fifo_en,
  input  wire logic                          dma_mode,
  input  wire logic [LEVEL_W-1:0]            rx_fill,
  input  wire logic [LEVEL_W-1:0]            rx_trig,
  input  wire logic [LEVEL_W-1:0]            tx_fill,
  input  wire logic [LEVEL_W-1:0]            tx_trig,
  input  wire logic                          tx_shift_empty,
  input  wire logic                          thr_write,
  input  wire logic                          rx_timeout,
  input  wire logic                          xoff_rcvd,
  input  wire logic [3:0]                    modem_delta,
  input  wire logic [3:0]                    rx_err,
  input  wire logic                          fifo_err,
  // Modem lines
  input  wire logic                          cts_pin,
  input  wire logic                          rts_out,
  // Outputs
  output logic                               irq,
  output logic                               transmit_ready_n,
  output logic                               receive_ready_n,
  output logic                               sleep_en
);
  import uirl_pkg::*;

  // All channel state lives in one packed struct: synchroniser and
  // edge-detect history, sticky sources, registered pins and read data.
  // One comb process builds the next copy and one flop stores it, so no
  // field can end up with a second driver.
  typedef struct packed {
    logic [7:0] mask;
    logic       cts_s1;
    logic       cts_s2;
    logic       cts_d;
    logic       rts_d;
    logic       tx_empty_d;
    logic       cts_pend;
    logic       rts_pend;
    logic       xoff_pend;
    logic       tx_pend;
    logic       irq;
    logic       tx_rdy_n;
    logic       rx_rdy_n;
    logic [7:0] rdata;
  } uirl_chan_st_t;

  // Ready pins idle high, everything else starts at zero.
  localparam uirl_chan_st_t UIRL_ST_RST = '{
    mask:     UIRL_MASK_RST,
    tx_rdy_n: 1'b1,
    rx_rdy_n: 1'b1,
    default:  '0
  };

  uirl_chan_st_t q;
  uirl_chan_st_t n;

  // Decoded strobes and combinational views of this cycle's inputs. All
  // get a value at the top of the comb process, so none can latch.
  logic       cts_rise;
  logic       rts_rise;
  logic       tx_empty;
  logic       rx_cond;
  logic       rx_int;
  logic       line_int;
  logic       modem_int;
  logic       ready_mode1;
  logic       src_rd;
  logic       mask_wr;
  logic [7:0] src_stat;
  logic [7:0] line_stat;

  // Next state of the channel: edges, sticky sources, pins and read data.
  always_comb begin
    n           = q;
    cts_rise    = 1'b0;
    rts_rise    = 1'b0;
    tx_empty    = 1'b0;
    rx_cond     = 1'b0;
    rx_int      = 1'b0;
    line_int    = 1'b0;
    modem_int   = 1'b0;
    ready_mode1 = 1'b0;
    src_rd      = 1'b0;
    mask_wr     = 1'b0;
    src_stat    = 8'h00;
    line_stat   = 8'h00;

    // The pin passes two flops; the edge is taken after the second.
    // Only the second flop feeds logic, so a metastable first stage never
    // reaches the edge detector. The price is two cycles of latency.
    // The request-to-send line is ours and already on this clock.
    n.cts_s1 = cts_pin;
    n.cts_s2 = q.cts_s1;
    n.cts_d  = q.cts_s2;
    n.rts_d  = rts_out;
    cts_rise = q.cts_s2 & ~q.cts_d;
    rts_rise = rts_out & ~q.rts_d;

    // Strobes arrive already qualified by the channel decode in the top.
    // Level sources read the stored mask, so a new mask acts from the next
    // edge; the transmit source follows the written value at once.
    src_rd  = rd & (reg_sel == UIRL_OFS_SRC);
    mask_wr = wr & (reg_sel == UIRL_OFS_MASK);
    if (mask_wr) begin
      n.mask = wdata;
    end

    // Without FIFOs the fill is the holding register occupancy, 0 or 1.
    tx_empty     = (tx_fill == '0);
    n.tx_empty_d = tx_empty;
    ready_mode1  = fifo_en & dma_mode;

    // Level sources follow their cause and need no clearing.
    if (fifo_en) begin
      rx_cond = (rx_fill >= rx_trig);
    end else begin
      rx_cond = (rx_fill != '0);
    end
    // With the low four enables clear these stay silent for polling.
    rx_int    = q.mask[UIRL_MB_RX] & rx_cond;
    line_int  = q.mask[UIRL_MB_LINE] & (|rx_err);
    modem_int = q.mask[UIRL_MB_MODEM] & (|modem_delta);

    // Edge sources are sticky until software reads the source status.
    // The clear comes first so a same-cycle event survives the read.
    if (src_rd) begin
      n.cts_pend  = 1'b0;
      n.rts_pend  = 1'b0;
      n.xoff_pend = 1'b0;
    end
    if (cts_rise & q.mask[UIRL_MB_CTS]) begin
      n.cts_pend = 1'b1;
    end
    if (rts_rise & q.mask[UIRL_MB_RTS]) begin
      n.rts_pend = 1'b1;
    end
    if (xoff_rcvd & q.mask[UIRL_MB_XOFF]) begin
      n.xoff_pend = 1'b1;
    end

    // Transmit empty is an event: the path just drained, or software
    // enabled the source while already empty. Read or new data clears.
    if (src_rd | thr_write) begin
      n.tx_pend = 1'b0;
    end
    if (q.mask[UIRL_MB_TX] & tx_empty & ~q.tx_empty_d) begin
      n.tx_pend = 1'b1;
    end
    if (mask_wr & wdata[UIRL_MB_TX] & ~q.mask[UIRL_MB_TX] & tx_empty) begin
      n.tx_pend = 1'b1;
    end
    if (~n.mask[UIRL_MB_TX]) begin
      n.tx_pend = 1'b0;
    end

    // One interrupt line per channel, registered for a clean output.
    // Edge sources enter with their next value, so a read that clears a
    // pending bit drops the line on the same edge and the host never sees
    // a stale interrupt for an extra cycle.
    n.irq = rx_int | line_int | modem_int | n.tx_pend
          | n.xoff_pend | n.cts_pend | n.rts_pend;

    // Transmit ready pin.
    // In mode 0 a host write wins over empty, so the pin goes high on the
    // first character even when the path drains it again at once.
    if (ready_mode1) begin
      n.tx_rdy_n = ~(tx_fill < tx_trig);
    end else if (thr_write) begin
      n.tx_rdy_n = 1'b1;
    end else if (tx_empty) begin
      n.tx_rdy_n = 1'b0;
    end

    // Receive ready pin; in mode 1 it latches low until the FIFO is empty,
    // which keeps it low through any fill above the trigger.
    if (ready_mode1) begin
      if ((rx_fill >= rx_trig) | rx_timeout) begin
        n.rx_rdy_n = 1'b0;
      end else if (rx_fill == '0) begin
        n.rx_rdy_n = 1'b1;
      end
    end else begin
      n.rx_rdy_n = (rx_fill == '0);
    end

    // Source status shows raw causes so polling software sees them too.
    // The level causes here are unmasked; the interrupt line is not.
    src_stat[UIRL_SS_RX]    = rx_cond;
    src_stat[UIRL_SS_TX]    = q.tx_pend;
    src_stat[UIRL_SS_LINE]  = |rx_err;
    src_stat[UIRL_SS_MODEM] = |modem_delta;
    src_stat[UIRL_SS_XOFF]  = q.xoff_pend;
    src_stat[UIRL_SS_CTS]   = q.cts_pend;
    src_stat[UIRL_SS_RTS]   = q.rts_pend;
    src_stat[UIRL_SS_IRQ]   = q.irq;

    // Line condition status.
    line_stat[UIRL_LS_RXDATA]  = (rx_fill != '0);
    line_stat[UIRL_LS_ERR_HI:UIRL_LS_ERR_LO] = rx_err;
    line_stat[UIRL_LS_THR_MT]  = tx_empty;
    line_stat[UIRL_LS_TX_IDLE] = tx_empty & tx_shift_empty;
    line_stat[UIRL_LS_FIFOERR] = fifo_err;

    // Read data stands only in the cycle after the strobe.
    if (rd) begin
      if (reg_sel == UIRL_OFS_MASK) begin
        n.rdata = q.mask;
      end else if (reg_sel == UIRL_OFS_SRC) begin
        n.rdata = src_stat;
      end else if (reg_sel == UIRL_OFS_LINE) begin
        n.rdata = line_stat;
      end else begin
        n.rdata = 8'h00;
      end
    end else begin
      n.rdata = 8'h00;
    end
  end

  // State register.
  // The reset branch loads only the constant image, so sleep stays off
  // and every source stays masked until software writes the mask.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= UIRL_ST_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from flops.
  // No logic sits after the flops, so the pins cannot glitch.
  assign rdata            = q.rdata;
  assign irq              = q.irq;
  assign transmit_ready_n = q.tx_rdy_n;
  assign receive_ready_n  = q.rx_rdy_n;
  assign sleep_en         = q.mask[UIRL_MB_SLEEP];

endmodule

module uirl_top
  import uirl_pkg::*;
#(
  parameter int NCH     = UIRL_NCH,
  parameter int LEVEL_W = UIRL_LEVEL_W
) (
  // Clock and reset
  input  wire logic                                mclk,
  input  wire logic                                resetn,
  // Register port
  input  wire logic [uirl_pkg::UIRL_ADDR_W-1:0]    addr,
  input  wire logic [7:0]                          wdata,
  input  wire logic                                wr,
  input  wire logic                                rd,
  output logic      [7:0]                          rdata,
  // FIFO and serial engine state, one entry per channel
  input  wire logic [NCH-1:0]                      fifo_en,
  input  wire logic [NCH-1:0]                      dma_mode,
  input  wire logic [NCH-1:0][LEVEL_W-1:0]         rx_fill,
  input  wire logic [NCH-1:0][LEVEL_W-1:0]         rx_trig,
  input  wire logic [NCH-1:0][LEVEL_W-1:0]         tx_fill,
  input  wire logic [NCH-1:0][LEVEL_W-1:0]         tx_trig,
  input  wire logic [NCH-1:0]                      tx_shift_empty,
  input  wire logic [NCH-1:0]                      thr_write,
  input  wire logic [NCH-1:0]                      rx_timeout,
  input  wire logic [NCH-1:0]                      xoff_rcvd,
  input  wire logic [NCH-1:0][3:0]                 modem_delta,
  input  wire logic [NCH-1:0][3:0]                 rx_err,
  input  wire logic [NCH-1:0]                      fifo_err,
  // Modem lines
  input  wire logic [NCH-1:0]                      clear_to_send_inputs,
  input  wire logic [NCH-1:0]                      request_to_send_outputs,
  // Interrupt and ready pins
  output logic                                     irq_out_first_channel,
  output logic                                     irq_out_second_channel,
  output logic      [NCH-1:0]                      transmit_ready_pins,
  output logic      [NCH-1:0]                      receive_ready_pins,
  output logic      [NCH-1:0]                      sleep_en
);
  import uirl_pkg::*;

  logic [NCH-1:0][7:0] ch_rdata;
  logic [NCH-1:0]      ch_irq;

  // One channel per address slot; strobes reach only the selected one.
  // Unselected channels see both strobes low, so their read-to-clear
  // bits are safe from reads aimed at the other channel.
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic hit;
    assign hit = (addr[UIRL_ADDR_W-1:UIRL_SEL_W] == UIRL_CH_W'(c));
    uirl_chan #(
      .LEVEL_W (LEVEL_W)
    ) u_chan (
      .mclk             (mclk),
      .resetn           (resetn),
      .reg_sel          (addr[UIRL_SEL_W-1:0]),
      .wdata            (wdata),
      .wr               (wr & hit),
      .rd               (rd & hit),
      .rdata            (ch_rdata[c]),
      .fifo_en          (fifo_en[c]),
      .dma_mode         (dma_mode[c]),
      .rx_fill          (rx_fill[c]),
      .rx_trig          (rx_trig[c]),
      .tx_fill          (tx_fill[c]),
      .tx_trig          (tx_trig[c]),
      .tx_shift_empty   (tx_shift_empty[c]),
      .thr_write        (thr_write[c]),
      .rx_timeout       (rx_timeout[c]),
      .xoff_rcvd        (xoff_rcvd[c]),
      .modem_delta      (modem_delta[c]),
      .rx_err           (rx_err[c]),
      .fifo_err         (fifo_err[c]),
      .cts_pin          (clear_to_send_inputs[c]),
      .rts_out          (request_to_send_outputs[c]),
      .irq              (ch_irq[c]),
      .transmit_ready_n (transmit_ready_pins[c]),
      .receive_ready_n  (receive_ready_pins[c]),
      .sleep_en         (sleep_en[c])
    );
  end

  // Idle channels return zero, so a plain OR merges the read data.
  // This relies on every channel clearing its read data after one cycle.
  always_comb begin
    rdata = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      rdata = rdata | ch_rdata[i];
    end
  end

  // Two named interrupt pins; a single-channel build leaves one low.
  assign irq_out_first_channel  = ch_irq[0];
  assign irq_out_second_channel = (NCH > 1) ? ch_irq[NCH-1] : 1'b0;

endmodule

/* uirl_pkg.sv */
// Purpose: Shared constants for the UART interrupt and ready logic.
// Assumes: One register word of 8 bits per offset, per channel.
// Notes:   Channel number sits above the register select in the address.
package uirl_pkg;

  // Structure of the block.
  localparam int UIRL_NCH     = 2;
  localparam int UIRL_ADDR_W  = 4;
  localparam int UIRL_SEL_W   = 3;
  localparam int UIRL_CH_W    = UIRL_ADDR_W - UIRL_SEL_W;
  localparam int UIRL_LEVEL_W = 8;

  // Register offsets within one channel.
  localparam logic [UIRL_SEL_W-1:0] UIRL_OFS_MASK = 3'h0;
  localparam logic [UIRL_SEL_W-1:0] UIRL_OFS_SRC  = 3'h1;
  localparam logic [UIRL_SEL_W-1:0] UIRL_OFS_LINE = 3'h2;

  // Reset value of interrupt_mask_control.
  localparam logic [7:0] UIRL_MASK_RST = 8'h00;

  // Bit positions in interrupt_mask_control.
  localparam int UIRL_MB_RX    = 0;
  localparam int UIRL_MB_TX    = 1;
  localparam int UIRL_MB_LINE  = 2;
  localparam int UIRL_MB_MODEM = 3;
  localparam int UIRL_MB_SLEEP = 4;
  localparam int UIRL_MB_XOFF  = 5;
  localparam int UIRL_MB_RTS   = 6;
  localparam int UIRL_MB_CTS   = 7;

  // Bit positions in interrupt_source_status.
  localparam int UIRL_SS_RX    = 0;
  localparam int UIRL_SS_TX    = 1;
  localparam int UIRL_SS_LINE  = 2;
  localparam int UIRL_SS_MODEM = 3;
  localparam int UIRL_SS_XOFF  = 4;
  localparam int UIRL_SS_CTS   = 5;
  localparam int UIRL_SS_RTS   = 6;
  localparam int UIRL_SS_IRQ   = 7;

  // Bit positions in line_condition_status.
  localparam int UIRL_LS_RXDATA  = 0;
  localparam int UIRL_LS_ERR_LO  = 1;
  localparam int UIRL_LS_ERR_HI  = 4;
  localparam int UIRL_LS_THR_MT  = 5;
  localparam int UIRL_LS_TX_IDLE = 6;
  localparam int UIRL_LS_FIFOERR = 7;

endpackage

/* uirl_chk.sv */
// Purpose: Assertions on channel 0 interrupt, sleep and ready pins.
// Assumes: A shadow of the channel 0 mask tracks register writes.
// Notes:   Channel 1 is judged by the bench's own comparisons.
module uirl_chk
  import uirl_pkg::*;
#(
  parameter int NCH     = UIRL_NCH,
  parameter int LEVEL_W = UIRL_LEVEL_W
) (
  // Clock, reset and register writes
  input wire logic                      mclk,
  input wire logic                      resetn,
  input wire logic [3:0]                addr,
  input wire logic [7:0]                wdata,
  input wire logic                      wr,
  // Engine state
  input wire logic [NCH-1:0]            fifo_en,
  input wire logic [NCH-1:0]            dma_mode,
  input wire logic [NCH-1:0][LEVEL_W-1:0] rx_fill,
  input wire logic [NCH-1:0][LEVEL_W-1:0] rx_trig,
  input wire logic [NCH-1:0][LEVEL_W-1:0] tx_fill,
  input wire logic [NCH-1:0][LEVEL_W-1:0] tx_trig,
  input wire logic [NCH-1:0][3:0]       modem_delta,
  input wire logic [NCH-1:0][3:0]       rx_err,
  // Pins
  input wire logic                      irq_out_first_channel,
  input wire logic [NCH-1:0]            transmit_ready_pins,
  input wire logic [NCH-1:0]            receive_ready_pins,
  input wire logic [NCH-1:0]            sleep_en
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mask0;
  logic       m1;

  // Shadow mask moves on the same edge as the design's own copy.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask0 <= 8'h00;
    end else if (wr && addr == 4'h0) begin
      mask0 <= wdata;
    end
  end
  assign m1 = fifo_en[0] & dma_mode[0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence mask_wr_s;
    wr && addr == 4'h0;
  endsequence
  sequence modem_s;
    mask0[3] && (|modem_delta[0]);
  endsequence

  sleep_bit_a: assert property (
    mask_wr_s |=> sleep_en[0] == $past(wdata[4]))
    else $error("sleep enable differs from mask bit 4");
  reset_sleep_a: assert property (
    $rose(resetn) |-> sleep_en == 2'b00)
    else $error("sleep enabled after reset");
  modem_irq_a: assert property (
    modem_s |=> irq_out_first_channel)
    else $error("modem change gave no interrupt");
  line_irq_a: assert property (
    mask0[2] && (|rx_err[0]) |=> irq_out_first_channel)
    else $error("receive error gave no interrupt");
  // A mask write in the same cycle is left out: enabling the transmit
  // source while already empty may raise the line on the next edge.
  polled_quiet_a: assert property (
    fifo_en[0] && mask0 == 8'h00 && $past(mask0) == 8'h00 &&
    !(wr && addr == 4'h0)
    |=> !irq_out_first_channel)
    else $error("interrupt in polled mode");
  m0_rx_a: assert property (
    $past(resetn) && !$past(m1)
    |-> receive_ready_pins[0] == ($past(rx_fill[0]) == '0))
    else $error("receive ready wrong in mode 0");
  m1_tx_a: assert property (
    $past(resetn) && $past(m1)
    |-> transmit_ready_pins[0] == ($past(tx_fill[0]) >= $past(tx_trig[0])))
    else $error("transmit ready wrong in mode 1");
  m1_rx_a: assert property (
    m1 && rx_fill[0] >= rx_trig[0] && rx_fill[0] != '0
    |=> !receive_ready_pins[0])
    else $error("receive ready not low at trigger");
endmodule

/* uirl_far.sv */
// Purpose: Far-side model of the channel 0 FIFOs and serial engine.
// Assumes: One character moves per strobe cycle.
// Notes:   Levels saturate so a stray pop never wraps to full.
module uirl_far #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Strobes: rx in, rx out, tx in, tx out
  input  wire logic [3:0] op,
  // Levels and host write pulse
  output logic      [7:0] rx_lvl,
  output logic      [7:0] tx_lvl,
  output logic            thr_wr
);
  timeunit 1ns;
  timeprecision 1ps;

  // A host write shows in the same cycle it enters the FIFO.
  assign thr_wr = op[2];

  // Receive keeps filling until full; the serializer drains transmit.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_lvl <= 8'h00;
      tx_lvl <= 8'h00;
    end else begin
      if (op[0] && rx_lvl < DEPTH) rx_lvl <= rx_lvl + 8'h01;
      else if (op[1] && rx_lvl != 8'h00) rx_lvl <= rx_lvl - 8'h01;
      if (op[2] && tx_lvl < DEPTH) tx_lvl <= tx_lvl + 8'h01;
      else if (op[3] && tx_lvl != 8'h00) tx_lvl <= tx_lvl - 8'h01;
    end
  end
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the interrupt and ready logic.
// Assumes: Channel 0 levels come from the far-side model.
// Notes:   Channel 1 levels, stop and time-out inputs stay idle.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic            mclk, resetn, wr, rd, thw, i0, i1;
  logic [3:0]      addr;
  logic [5:0]      op;
  logic [7:0]      wdata, rdata, rtrig, ttrig, prx, ptx;
  logic [1:0]      fe, dm, tse, ferr, cts, rts, txp, rxp, slp;
  logic [1:0][3:0] md, re;
  int              mismatches, cmp_count, cycles;

  uirl_top dut (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .fifo_en(fe), .dma_mode(dm),
    .rx_fill({8'h00, prx}), .rx_trig({rtrig, rtrig}),
    .tx_fill({8'h00, ptx}), .tx_trig({ttrig, ttrig}),
    .tx_shift_empty(tse), .thr_write({1'b0, thw}),
    .rx_timeout({1'b0, op[5]}), .xoff_rcvd({1'b0, op[4]}),
    .modem_delta(md), .rx_err(re), .fifo_err(ferr),
    .clear_to_send_inputs(cts), .request_to_send_outputs(rts),
    .irq_out_first_channel(i0), .irq_out_second_channel(i1),
    .transmit_ready_pins(txp), .receive_ready_pins(rxp), .sleep_en(slp));
  uirl_far far (.mclk(mclk), .resetn(resetn), .op(op[3:0]),
    .rx_lvl(prx), .tx_lvl(ptx), .thr_wr(thw));

  // Free-running clock and a hang guard far above the expected run.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  // Outputs are read 1 ns past the edge so its updates have landed.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // Each strobe is one cycle with a gap, so no edge sees two drives.
  task automatic fop(input int k, input int n);
    repeat (n) begin
      @(posedge mclk);
      op[k] <= 1'b1;
      @(posedge mclk);
      op[k] <= 1'b0;
    end
  endtask

  task automatic t_regs();
    rchk(4'h0, 8'h00);
    chk({6'h00, slp}, 8'h00);
    wreg(4'h0, 8'h10);
    rchk(4'h0, 8'h10);
    chk({6'h00, slp}, 8'h01);
    wreg(4'hb, 8'h5a);
    rchk(4'hb, 8'h00);
    wreg(4'h8, 8'h41);
    rchk(4'h8, 8'h41);
    wreg(4'h0, 8'h00);
  endtask
  task automatic t_lines();
    @(posedge mclk);
    md[0] <= 4'h4;
    re[0] <= 4'ha;
    ferr[0] <= 1'b1;
    cyc(2);
    cb(i0, 1'b0);
    wreg(4'h0, 8'h08);
    cyc(2);
    cb(i0, 1'b1);
    wreg(4'h0, 8'h04);
    rchk(4'h2, 8'hf4);
    cb(i0, 1'b1);
    @(posedge mclk);
    re[0] <= 4'h0;
    ferr[0] <= 1'b0;
    md <= {4'h1, 4'h0};
    wreg(4'h8, 8'h08);
    cyc(2);
    cb(i0, 1'b0);
    cb(i1, 1'b1);
    cb(txp[1], 1'b0);
    cb(rxp[1], 1'b1);
    wreg(4'h0, 8'h01);
  endtask
  task automatic t_rx();
    fop(0, 1);
    cyc(2);
    rchk(4'h1, 8'h81);
    fop(1, 1);
    cyc(2);
    cb(i0, 1'b0);
    @(posedge mclk);
    fe[0] <= 1'b1;
    rtrig <= 8'h03;
    fop(0, 2);
    cyc(2);
    rchk(4'h1, 8'h00);
    fop(0, 1);
    cyc(2);
    rchk(4'h1, 8'h81);
    rchk(4'h2, 8'h61);
    fop(1, 1);
    cyc(2);
    rchk(4'h1, 8'h00);
    fop(1, 2);
    rchk(4'h2, 8'h60);
    wreg(4'h0, 8'h00);
  endtask
  task automatic t_tx();
    @(posedge mclk);
    tse[0] <= 1'b0;
    fop(2, 2);
    wreg(4'h0, 8'h02);
    cyc(2);
    cb(i0, 1'b0);
    fop(3, 2);
    cyc(2);
    rchk(4'h2, 8'h20);
    rchk(4'h1, 8'h82);
    cyc(2);
    cb(i0, 1'b0);
    wreg(4'h0, 8'h00);
    wreg(4'h0, 8'h02);
    cyc(2);
    cb(i0, 1'b1);
    fop(2, 1);
    cyc(2);
    cb(i0, 1'b0);
    wreg(4'h0, 8'h00);
    fop(3, 1);
  endtask
  task automatic t_edge();
    wreg(4'h0, 8'h80);
    @(posedge mclk);
    cts[0] <= 1'b1;
    cyc(6);
    rchk(4'h1, 8'ha0);
    wreg(4'h0, 8'h40);
    @(posedge mclk);
    rts[0] <= 1'b1;
    cyc(2);
    rchk(4'h1, 8'hc0);
    wreg(4'h0, 8'h20);
    fop(4, 1);
    cyc(2);
    rchk(4'h1, 8'h90);
    cyc(2);
    cb(i0, 1'b0);
    wreg(4'h0, 8'h00);
    fop(4, 1);
    cyc(2);
    cb(i0, 1'b0);
  endtask
  task automatic t_poll();
    @(posedge mclk);
    md[0] <= 4'hf;
    re[0] <= 4'h1;
    tse[0] <= 1'b1;
    fop(0, 4);
    cyc(2);
    cb(i0, 1'b0);
    rchk(4'h2, 8'h63);
    @(posedge mclk);
    md[0] <= 4'h0;
    re[0] <= 4'h0;
    fop(1, 4);
  endtask
  task automatic t_ready();
    cyc(1);
    cb(txp[0], 1'b0);
    fop(2, 1);
    cyc(1);
    cb(txp[0], 1'b1);
    fop(0, 1);
    cyc(1);
    cb(rxp[0], 1'b0);
    fop(3, 1);
    fop(1, 1);
    cyc(1);
    cb(txp[0], 1'b0);
    cb(rxp[0], 1'b1);
    @(posedge mclk);
    dm[0] <= 1'b1;
    ttrig <= 8'h02;
    fop(2, 2);
    cyc(1);
    cb(txp[0], 1'b1);
    fop(3, 1);
    cyc(1);
    cb(txp[0], 1'b0);
    fop(0, 2);
    cyc(1);
    cb(rxp[0], 1'b1);
    fop(0, 7);
    cyc(1);
    cb(rxp[0], 1'b0);
    fop(1, 7);
    cyc(1);
    cb(rxp[0], 1'b0);
    fop(1, 1);
    cyc(1);
    cb(rxp[0], 1'b1);
    fop(0, 1);
    fop(5, 1);
    cyc(1);
    cb(rxp[0], 1'b0);
  endtask

  // Reset, then each scenario in turn.
  initial begin
    {resetn, wr, rd, addr, wdata, op} = '0;
    {fe, dm, ferr, cts, rts, md, re, rtrig, ttrig} = '0;
    tse = 2'b11;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_lines();
    t_rx();
    t_tx();
    t_edge();
    t_poll();
    t_ready();
    summarize();
  end
endmodule

bind uirl_top uirl_chk #(.NCH(NCH), .LEVEL_W(LEVEL_W)) chk_i (
  .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
  .fifo_en(fifo_en), .dma_mode(dma_mode), .rx_fill(rx_fill),
  .rx_trig(rx_trig), .tx_fill(tx_fill), .tx_trig(tx_trig),
  .modem_delta(modem_delta), .rx_err(rx_err),
  .irq_out_first_channel(irq_out_first_channel),
  .transmit_ready_pins(transmit_ready_pins),
  .receive_ready_pins(receive_ready_pins), .sleep_en(sleep_en));
